// ==== src/adc_timing_defs.svh ====
`ifndef ADC_TIMING_DEFS_SVH
`define ADC_TIMING_DEFS_SVH
`define TIMING_CTRL_OFFSET  8'h00
`define STATUS_OFFSET       8'h04
`define CLK_SRC_BIT         15
`define SAMPLE_MSB          12
`define SAMPLE_LSB          8
`define DIV_MSB             7
`define DIV_LSB             0
`define TIMING_CTRL_RESET   16'h0000
`define IMPL_MASK           16'h9fff
`define AUTO_TRIG_SRC       3'h7
`define AXI_RESP_OKAY       2'h0
`define AXI_RESP_SLVERR     2'h2
`endif

// ==== src/adc_timing_pkg.sv ====
`default_nettype none
package adc_timing_pkg;
  typedef enum logic [2:0]
  {
    phase_idle   = 3'h1,
    phase_sample = 3'h2,
    phase_done   = 3'h4
  } sample_state_t;
endpackage
`default_nettype wire

// ==== src/clk_div_if.sv ====
`default_nettype none
interface clk_div_if;
  logic [7:0] divider;
  logic       tick;
  modport ctrl (output divider, input tick);
  modport gen  (input divider, output tick);
endinterface
`default_nettype wire

// ==== src/conv_clock_divider_gen.sv ====
`default_nettype none
module conv_clock_divider_gen
(
  input  wire logic aclk,
  input  wire logic aresetn,
  clk_div_if.gen    div
);
  logic [8:0] count_q;
  // reload at period boundary so a new divider only takes effect there
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count_q  <= 9'h001;
      div.tick <= 1'b0;
    end
    else if (count_q <= 9'h001)
    begin
      count_q  <= {1'b0, div.divider} + 9'h001;
      div.tick <= 1'b1;
    end
    else
    begin
      count_q  <= count_q - 9'h001;
      div.tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== src/adc_conversion_timing_control.sv ====
`default_nettype none
`include "adc_timing_defs.svh"
module adc_conversion_timing_control
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        rc_clock_tick,
  input  wire logic [2:0]  conversion_trigger_source,
  input  wire logic        trigger_source_group,
  input  wire logic        sample_start,
  output var  logic        conv_clock_tick,
  output var  logic        auto_sample_active,
  output var  logic        auto_sample_done
);
  // ***************************************************
  // register and bus
  // ***************************************************
  logic [15:0] ctrl_q;
  logic [31:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        aw_have_q;
  logic        w_have_q;
  logic [1:0]  rc_sync_q;
  logic        rc_prev_q;
  logic        rc_edge;
  logic        sys_tick;
  logic        period_tick;
  logic        auto_mode;
  logic [4:0]  sample_cnt_q;
  adc_timing_pkg::sample_state_t state_q;
  clk_div_if div_bus ();

  function automatic logic [15:0] merge_bytes(input logic [15:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0]  strb);
    logic [15:0] r;
    r = old;
    if (strb[0])
      r[7:0] = data[7:0];
    if (strb[1])
      r[15:8] = data[15:8];
    return r & `IMPL_MASK;
  endfunction

  // word-aligned register hit, byte lanes [1:0] ignored
  function automatic logic reg_hit(input logic [31:0] addr,
                                   input logic [7:0]  offset);
    return addr[31:8] == 24'h000000 && addr[7:2] == offset[7:2];
  endfunction

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      awaddr_q      <= 32'h0000_0000;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `AXI_RESP_OKAY;
      ctrl_q        <= `TIMING_CTRL_RESET;
    end
    else
    begin
      s_axi_awready <= !aw_have_q && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_have_q && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (aw_have_q && w_have_q && !s_axi_bvalid)
      begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (reg_hit(awaddr_q, `TIMING_CTRL_OFFSET))
        begin
          ctrl_q      <= merge_bytes(ctrl_q, wdata_q, wstrb_q);
          s_axi_bresp <= `AXI_RESP_OKAY;
        end
        else if (reg_hit(awaddr_q, `STATUS_OFFSET))
          s_axi_bresp <= `AXI_RESP_OKAY;
        else
          s_axi_bresp <= `AXI_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // read answer one cycle after arvalid is seen with arready
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `AXI_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        if (reg_hit(s_axi_araddr, `TIMING_CTRL_OFFSET))
        begin
          s_axi_rdata <= {16'h0000, ctrl_q & `IMPL_MASK};
          s_axi_rresp <= `AXI_RESP_OKAY;
        end
        else if (reg_hit(s_axi_araddr, `STATUS_OFFSET))
        begin
          s_axi_rdata <= {24'h000000, auto_mode, state_q, sample_cnt_q[3:0]};
          s_axi_rresp <= `AXI_RESP_OKAY;
        end
        else
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `AXI_RESP_SLVERR;
        end
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ***************************************************
  // conversion clock
  // ***************************************************
  assign div_bus.divider = ctrl_q[`DIV_MSB:`DIV_LSB];
  assign sys_tick        = div_bus.tick;

  conv_clock_divider_gen u_div
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .div     (div_bus.gen)
  );

  // rc clock arrives from another domain: two flops, then edge detect
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rc_sync_q <= 2'h0;
      rc_prev_q <= 1'b0;
    end
    else
    begin
      rc_sync_q <= {rc_sync_q[0], rc_clock_tick};
      rc_prev_q <= rc_sync_q[1];
    end
  end
  assign rc_edge = rc_sync_q[1] && !rc_prev_q;

  // divider output is simply unused under rc selection
  assign period_tick = ctrl_q[`CLK_SRC_BIT] ? rc_edge : sys_tick;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      conv_clock_tick <= 1'b0;
    else
      conv_clock_tick <= period_tick;
  end

  // ***************************************************
  // auto sample timing
  // ***************************************************
  assign auto_mode = conversion_trigger_source == `AUTO_TRIG_SRC && !trigger_source_group;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q            <= adc_timing_pkg::phase_idle;
      sample_cnt_q       <= 5'h00;
      auto_sample_active <= 1'b0;
      auto_sample_done   <= 1'b0;
    end
    else
    begin
      auto_sample_done <= 1'b0;
      case (state_q)
        adc_timing_pkg::phase_idle:
        begin
          if (sample_start && auto_mode)
          begin
            sample_cnt_q       <= ctrl_q[`SAMPLE_MSB:`SAMPLE_LSB];
            state_q            <= adc_timing_pkg::phase_sample;
            auto_sample_active <= 1'b1;
          end
        end
        adc_timing_pkg::phase_sample:
        begin
          if (sample_cnt_q == 5'h00)
          begin
            state_q            <= adc_timing_pkg::phase_done;
            auto_sample_active <= 1'b0;
            auto_sample_done   <= 1'b1;
          end
          else if (period_tick)
            sample_cnt_q <= sample_cnt_q - 5'h01;
        end
        adc_timing_pkg::phase_done:
          state_q <= adc_timing_pkg::phase_idle;
        default:
          state_q <= adc_timing_pkg::phase_idle;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== bench/converter_core_model.sv ====
`default_nettype none
// ****************
// converter core side
// ****************
module converter_core_model
(
  input  wire logic       aclk,
  output var  logic       rc_clock_tick,
  output var  logic [2:0] conversion_trigger_source,
  output var  logic       trigger_source_group,
  output var  logic       sample_start
);
  timeunit 1ns;
  timeprecision 100ps;
  // free-running rc clock, period of 14 system cycles, edges on the falling system edges
  initial
  begin
    rc_clock_tick = 1'b0;
    conversion_trigger_source = 3'h0;
    trigger_source_group = 1'b0;
    sample_start = 1'b0;
    forever #175 rc_clock_tick = ~rc_clock_tick;
  end
  task set_trig(input logic [2:0] s, input logic g);
    @(posedge aclk);
    conversion_trigger_source <= s;
    trigger_source_group <= g;
  endtask
  task start();
    @(posedge aclk);
    sample_start <= 1'b1;
    @(posedge aclk);
    sample_start <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== bench/adc_timing_assertions.sv ====
`default_nettype none
// ****************
// port checks
// ****************
module adc_timing_assertions
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        sample_start,
  input wire logic [2:0]  conversion_trigger_source,
  input wire logic        trigger_source_group,
  input wire logic        auto_sample_active,
  input wire logic        auto_sample_done,
  input wire logic        conv_clock_tick
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_reset_quiet: assert property ($rose(aresetn) |->
    !auto_sample_active && !s_axi_rvalid && !s_axi_bvalid) else $error("busy after reset");
  a_start_gate: assert property (sample_start && !auto_sample_active &&
    (conversion_trigger_source != 3'h7 || trigger_source_group) |=> !auto_sample_active)
    else $error("sampling without auto trigger");
  a_start_cause: assert property ($rose(auto_sample_active) |-> $past(sample_start) &&
    $past(conversion_trigger_source) == 3'h7 && !$past(trigger_source_group))
    else $error("sampling without start");
  a_done_pulse: assert property (auto_sample_done |=> !auto_sample_done)
    else $error("done longer than one cycle");
  a_done_after: assert property (auto_sample_done |->
    auto_sample_active || $past(auto_sample_active)) else $error("done without sampling");
  a_rdata_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000 &&
    s_axi_rdata[14:13] == 2'h0) else $error("unused bits not zero");
  // ready pulses on its own, so only a real handshake asks for an answer
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read answer");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("no write answer");
  cover property (auto_sample_done);
  cover property (conv_clock_tick);
  cover property (s_axi_awready && s_axi_wready);
endmodule
bind adc_conversion_timing_control adc_timing_assertions u_chk
(
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_wvalid, .s_axi_arvalid,
  .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rdata, .sample_start, .conversion_trigger_source,
  .trigger_source_group, .auto_sample_active, .auto_sample_done, .conv_clock_tick
);
`default_nettype wire

// ==== bench/tb_adc_conversion_timing_control.sv ====
`default_nettype none
`include "adc_timing_defs.svh"
// ****************
// bench
// ****************
module tb_adc_conversion_timing_control;
  timeunit 1ns;
  timeprecision 100ps;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, rc, grp, start, tick, act, done;
  logic [31:0] awaddr, wdata, araddr, rdata, d;
  logic [3:0]  wstrb;
  logic [2:0]  src;
  logic [1:0]  bresp, rresp, r;
  int          n_mismatch, comparisons, n, nd;
  logic [31:0] divs[3] = '{32'h0, 32'h3, 32'hff};
  adc_conversion_timing_control dut
  (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rc_clock_tick(rc), .conversion_trigger_source(src), .trigger_source_group(grp),
    .sample_start(start), .conv_clock_tick(tick), .auto_sample_active(act),
    .auto_sample_done(done)
  );
  converter_core_model core
  (
    .aclk(aclk), .rc_clock_tick(rc), .conversion_trigger_source(src),
    .trigger_source_group(grp), .sample_start(start)
  );
  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task stop_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // each task starts on a fresh edge so no signal is assigned twice in one step
  task wr(input logic [31:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (awvalid || wvalid);
    bready <= 1'b1;
    do @(posedge aclk); while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    v = rdata; rs = rresp;
    rready <= 1'b0;
  endtask
  // cycles between two conversion clock ticks; two ticks skipped first, since the
  // period already running at a divider change still uses the old setting
  task per();
    repeat (2)
      do @(posedge aclk); while (!tick);
    n = 0;
    do begin @(posedge aclk); n++; end while (!tick);
  endtask
  task samp(input logic [4:0] f, input logic [2:0] s, input logic g, input int exp);
    wr(`TIMING_CTRL_OFFSET, {19'h0, f, 8'h00}, r);
    per();
    chk("sys period", n, 1);
    core.set_trig(s, g);
    core.start();
    n = 0;
    nd = 0;
    repeat (40)
    begin
      @(posedge aclk);
      if (act === 1'b1) n++;
      if (done === 1'b1) nd++;
    end
    chk("active cycles", n, exp);
    chk("done pulses", nd, (s == 3'h7 && !g) ? 1 : 0);
  endtask
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, aresetn} = '0;
    {awaddr, wdata, araddr} = '0;
    wstrb = 4'hf;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`TIMING_CTRL_OFFSET, d, r); chk("ctrl reset", d, 32'h0);
    rd(`STATUS_OFFSET, d, r); chk("status reset", d, 32'h10);
    wr(`TIMING_CTRL_OFFSET, 32'hffffffff, r); chk("bresp", r, 2'h0);
    rd(`TIMING_CTRL_OFFSET, d, r); chk("ctrl mask", d, 32'h9fff);
    wr(32'h8, 32'h1, r); chk("bresp unmapped", r, 2'h2);
    rd(32'h8, d, r); chk("rresp unmapped", r, 2'h2); chk("rdata unmapped", d, 32'h0);
    foreach (divs[i])
    begin
      wr(`TIMING_CTRL_OFFSET, divs[i], r); per(); chk("sys period", n, divs[i] + 1);
      wr(`TIMING_CTRL_OFFSET, divs[i] | 32'h8000, r); per(); chk("rc period", n, 14);
    end
    samp(5'h03, 3'h7, 1'b0, 4);
    samp(5'h00, 3'h7, 1'b0, 1);
    samp(5'h1f, 3'h7, 1'b0, 32);
    samp(5'h03, 3'h6, 1'b0, 0);
    samp(5'h03, 3'h7, 1'b1, 0);
    stop_test();
  end
  initial
  begin
    #300us;
    n_mismatch++;
    stop_test();
  end
endmodule
`default_nettype wire
